// ### design/ssof_pkg.sv
// Package of constants and types for the servo status output flags block
package ssof_pkg;
    // Output function codes
    localparam logic [7:0] FC_OFF        = 8'h00;
    localparam logic [7:0] FC_FAULT      = 8'h07;
    localparam logic [7:0] FC_OVL_WARN   = 8'h10;
    localparam logic [7:0] FC_WARN       = 8'h11;
    localparam logic [7:0] FC_POS_OVF    = 8'h12;
    localparam logic [7:0] FC_REV_SOFT   = 8'h13;
    localparam logic [7:0] FC_FWD_SOFT   = 8'h14;
    localparam logic [7:0] FC_CMD_DONE   = 8'h15;
    // Number of configurable outputs
    localparam int         NUM_DO        = 8;
    // Timer and percent widths
    localparam int         TMR_W         = 40;
    localparam int         PCT_W         = 7;
    // Percent divisor for the warning threshold
    localparam logic [TMR_W-1:0] PCT_FULL = 40'h0000000064;
    // Permissible overload time in ms and its cycle count at 100 MHz
    localparam int         CLK_MHZ       = 100;
    localparam int         OVL_TIME_MS   = 8000;
    localparam logic [TMR_W-1:0] OVL_CYC =
        TMR_W'(64'(OVL_TIME_MS) * 64'(CLK_MHZ) * 64'd1000);
    // Reset values
    localparam logic [TMR_W-1:0] TMR_RST  = 40'h0000000000;
    // Command tracking states
    typedef enum logic [1:0] {SSOF_IDLE, SSOF_RUN, SSOF_DONE} ssof_cmd_t;
endpackage

// ### design/ssof_status_flags.sv
// Servo status output flags: overload timer, fault, warning and limit flags
`timescale 1ns/10ps
module ssof_status_flags #(
    parameter logic [39:0] OVL_CYCLES = ssof_pkg::OVL_CYC  // Permissible overload cycles
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    // Overload, warning and fault causes
    input  wire logic                     overloadIn,       // Motor is overloaded
    input  wire logic [ssof_pkg::PCT_W-1:0] warnPercent,    // Warning percent setting
    input  wire logic                     revLimitErr,      // Reverse limit error
    input  wire logic                     fwdLimitErr,      // Forward limit error
    input  wire logic                     emergencyStop,    // Emergency stop
    input  wire logic                     serialCommErr,    // Serial link error
    input  wire logic                     underVoltage,     // Undervoltage
    input  wire logic                     otherFault,       // Other hard fault
    // Position and command status
    input  wire logic                     posCmdOverflow,   // Position command overflow
    input  wire logic                     revSoftReached,   // Reverse soft limit reached
    input  wire logic                     fwdSoftReached,   // Forward soft limit reached
    input  wire logic                     cmdStart,         // Procedure command started
    input  wire logic                     cmdGenDone,       // Command generation finished
    // Output function selection
    input  wire logic [8*ssof_pkg::NUM_DO-1:0] doFuncCode,  // Function code per output
    // Registered outputs
    output logic [ssof_pkg::NUM_DO-1:0]   doOut,            // Configurable outputs
    output logic                          overloadWarnFlag, // Overload warning
    output logic                          servoFaultFlag,   // Servo fault
    output logic                          warnFlag,         // General warning
    output logic                          overloadAlarm,    // Overload alarm latched
    output logic                          cmdDoneFlag       // Internal command done
);
    // Inputs from pins pass two flip-flops first
    // One synchroniser lane per single-bit status input
    localparam int NIN = 12;
    logic [NIN-1:0] syncA_r;                  // First stage
    logic [NIN-1:0] syncB_r;                  // Second stage
    logic [NIN-1:0] syncA_nxt;                // First stage next
    logic [NIN-1:0] syncB_nxt;                // Second stage next
    logic [ssof_pkg::PCT_W-1:0] pctA_r;       // Percent first stage
    logic [ssof_pkg::PCT_W-1:0] pctB_r;       // Percent second stage
    // Overload timing
    logic [ssof_pkg::TMR_W-1:0] ovlTmr_r;     // Continuous overload timer
    logic [ssof_pkg::TMR_W-1:0] ovlTmr_nxt;
    logic [ssof_pkg::TMR_W-1:0] warnThr;      // Scaled warning threshold
    logic                       alarm_r;      // Sticky overload alarm
    logic                       alarm_nxt;
    // Command tracking
    ssof_pkg::ssof_cmd_t        cmdSt_r;      // Command tracking state
    ssof_pkg::ssof_cmd_t        cmdSt_nxt;
    // Flags: overload warning, fault, warning, overflow, reverse, forward
    logic [5:0]                 flags_nxt;    // Computed flag levels
    logic [5:0]                 flags_r;      // Registered flag levels
    // Output levels ahead of the output register
    logic [ssof_pkg::NUM_DO-1:0] doOut_nxt;   // Selected flag per output

    // Synchronised inputs by name
    wire sOvl   = syncB_r[0];
    wire sRev   = syncB_r[1];
    wire sFwd   = syncB_r[2];
    wire sEstop = syncB_r[3];
    wire sComm  = syncB_r[4];
    wire sUv    = syncB_r[5];
    wire sOther = syncB_r[6];
    wire sPovf  = syncB_r[7];
    wire sRsl   = syncB_r[8];
    wire sFsl   = syncB_r[9];
    wire sStart = syncB_r[10];
    wire sDone  = syncB_r[11];

    // Flag selected by a function code
    function automatic logic selFlag(input logic [7:0] code, input logic [5:0] f,
                                     input logic done);
        if (code == ssof_pkg::FC_OVL_WARN) begin
            selFlag = f[0];
        end else if (code == ssof_pkg::FC_FAULT) begin
            selFlag = f[1];
        end else if (code == ssof_pkg::FC_WARN) begin
            selFlag = f[2];
        end else if (code == ssof_pkg::FC_POS_OVF) begin
            selFlag = f[3];
        end else if (code == ssof_pkg::FC_REV_SOFT) begin
            selFlag = f[4];
        end else if (code == ssof_pkg::FC_FWD_SOFT) begin
            selFlag = f[5];
        end else if (code == ssof_pkg::FC_CMD_DONE) begin
            selFlag = done;
        end else begin
            selFlag = 1'b0;                   // Unused codes read low
        end
    endfunction

    // Synchroniser next values
    always_comb begin
        // Lane order matches the names above
        syncA_nxt = {cmdGenDone, cmdStart, fwdSoftReached, revSoftReached,
                     posCmdOverflow, otherFault, underVoltage, serialCommErr,
                     emergencyStop, fwdLimitErr, revLimitErr, overloadIn};
        syncB_nxt = syncA_r;
    end

    // Synchroniser registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // Clear both stages
            syncA_r <= '0;
            syncB_r <= '0;
            pctA_r  <= '0;
            pctB_r  <= '0;
        end else begin
            // Shift one stage per edge
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
            pctA_r  <= warnPercent;
            pctB_r  <= pctA_r;
        end
    end

    // Scaled time: permissible cycles times percent over one hundred
    function automatic logic [ssof_pkg::TMR_W-1:0] TMR_W_MUL(
        input logic [ssof_pkg::TMR_W-1:0] t, input logic [ssof_pkg::PCT_W-1:0] p);
        logic [ssof_pkg::TMR_W+ssof_pkg::PCT_W-1:0] prod; // Wide enough for any percent
        prod = t * p;
        TMR_W_MUL = ssof_pkg::TMR_W'(prod / ssof_pkg::PCT_FULL);
    endfunction

    // Threshold is permissible time times percent
    assign warnThr = TMR_W_MUL(OVL_CYCLES, pctB_r);

    // Overload timer, alarm and command state next values
    always_comb begin
        ovlTmr_nxt = ovlTmr_r;
        alarm_nxt  = alarm_r;
        cmdSt_nxt  = cmdSt_r;
        // Timer counts only continuous overload
        if (!sOvl) begin
            ovlTmr_nxt = ssof_pkg::TMR_RST;
        end else if (ovlTmr_r <= OVL_CYCLES) begin
            // Stops one past the limit so the alarm condition holds
            ovlTmr_nxt = ovlTmr_r + 40'h0000000001;
        end
        // Alarm once full permissible time is exceeded, held until reset
        if (sOvl && ovlTmr_r > OVL_CYCLES) begin
            alarm_nxt = 1'b1;
        end
        // Completion follows command generation only
        case (cmdSt_r)
            ssof_pkg::SSOF_IDLE: begin
                // Done input ignored until a command starts
                if (sStart) begin
                    cmdSt_nxt = ssof_pkg::SSOF_RUN;
                end
            end
            ssof_pkg::SSOF_RUN: begin
                // Done low while the command executes
                if (sDone) begin
                    cmdSt_nxt = ssof_pkg::SSOF_DONE;
                end
            end
            default: begin
                // Finished; a new start clears done
                if (sStart) begin
                    cmdSt_nxt = ssof_pkg::SSOF_RUN;
                end
            end
        endcase
        // Flag levels
        flags_nxt[0] = sOvl && ovlTmr_r > warnThr;
        flags_nxt[2] = sRev | sFwd | sEstop | sComm | sUv;
        // Fault follows the registered warning, so the warning leads
        flags_nxt[1] = alarm_nxt | sOther | flags_r[2];
        flags_nxt[3] = sPovf;
        flags_nxt[4] = sRsl;
        flags_nxt[5] = sFsl;
        // Output mapping
        for (int i = 0; i < ssof_pkg::NUM_DO; i++) begin
            doOut_nxt[i] = selFlag(doFuncCode[8*i +: 8], flags_nxt,
                                   cmdSt_nxt == ssof_pkg::SSOF_DONE);
        end
    end

    // State registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // All state and outputs low
            ovlTmr_r         <= ssof_pkg::TMR_RST;
            alarm_r          <= 1'b0;
            cmdSt_r          <= ssof_pkg::SSOF_IDLE;
            flags_r          <= '0;
            doOut            <= '0;
            overloadWarnFlag <= 1'b0;
            servoFaultFlag   <= 1'b0;
            warnFlag         <= 1'b0;
            overloadAlarm    <= 1'b0;
            cmdDoneFlag      <= 1'b0;
        end else begin
            // Register the next values
            ovlTmr_r         <= ovlTmr_nxt;
            alarm_r          <= alarm_nxt;
            cmdSt_r          <= cmdSt_nxt;
            flags_r          <= flags_nxt;
            doOut            <= doOut_nxt;
            overloadWarnFlag <= flags_nxt[0];
            servoFaultFlag   <= flags_nxt[1];
            warnFlag         <= flags_nxt[2];
            overloadAlarm    <= alarm_nxt;
            cmdDoneFlag      <= cmdSt_nxt == ssof_pkg::SSOF_DONE;
        end
    end
endmodule

// ### test/ssof_host_model.sv
// Host controller that latches the drive outputs each clock
`timescale 1ns/10ps
module ssof_host_model (
    input wire logic       ref_clk,
    input wire logic [7:0] doOut,
    output logic [7:0]     seenOut
);
    // Level sampling of the outputs, as a PLC input card would
    always @(posedge ref_clk) seenOut <= doOut;
endmodule

// ### test/ssof_status_flags_properties.sv
// Concurrent checks on the status flag outputs, bound to the top module
`timescale 1ns/10ps
module ssof_checker #(
    parameter logic [39:0] OVL_CYCLES = 40'h0000000064  // Permissible overload cycles
) (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        overloadIn,
    input wire logic        revLimitErr,
    input wire logic        fwdLimitErr,
    input wire logic        emergencyStop,
    input wire logic        serialCommErr,
    input wire logic        underVoltage,
    input wire logic        otherFault,
    input wire logic        posCmdOverflow,
    input wire logic        cmdStart,
    input wire logic        cmdGenDone,
    input wire logic        overloadWarnFlag,
    input wire logic        servoFaultFlag,
    input wire logic        warnFlag,
    input wire logic        overloadAlarm,
    input wire logic        cmdDoneFlag,
    input wire logic [6:0]  warnPercent,
    input wire logic [63:0] doFuncCode,
    input wire logic [7:0]  doOut
);
    logic [15:0] ovlCnt_r;   // Consecutive overloaded cycles
    logic [15:0] ovlCnt_nxt;
    int          thr;        // Scaled warning threshold
    logic        anyWarn;    // Any of the five warning causes
    assign thr = int'(OVL_CYCLES) * int'(warnPercent) / 100;
    assign anyWarn = revLimitErr | fwdLimitErr | emergencyStop | serialCommErr | underVoltage;
    // Next count of the overload run
    always_comb ovlCnt_nxt = overloadIn ? ovlCnt_r + 16'h0001 : 16'h0000;
    // Count register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) ovlCnt_r <= 16'h0000;
        else ovlCnt_r <= ovlCnt_nxt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_OVL_WARN_AT: assert property ($rose(overloadWarnFlag) |->
        ovlCnt_r > thr && ovlCnt_r <= thr + 8) else $error("warning rose off threshold");
    AST_ALARM_AT: assert property ($rose(overloadAlarm) |->
        ovlCnt_r > OVL_CYCLES && ovlCnt_r <= OVL_CYCLES + 8) else $error("alarm off limit");
    AST_ALARM_STICKY: assert property (overloadAlarm |=> overloadAlarm)
        else $error("alarm dropped");
    AST_ALARM_FAULT: assert property (overloadAlarm |-> ##[0:2] servoFaultFlag)
        else $error("alarm without fault");
    AST_WARN_SET: assert property (anyWarn [*5] |-> warnFlag)
        else $error("warning missing");
    AST_WARN_CLR: assert property (!anyWarn [*5] |-> !warnFlag)
        else $error("warning without cause");
    AST_WARN_FIRST: assert property ($rose(warnFlag) |-> ##[0:2] servoFaultFlag)
        else $error("warning not followed by fault");
    AST_OVF_OUT: assert property ((doFuncCode[31:24] == 8'h12 && posCmdOverflow) [*6]
        |-> doOut[3]) else $error("overflow output low");
    AST_DONE_CLR: assert property ($rose(cmdStart) |-> ##[1:4] !cmdDoneFlag)
        else $error("done not cleared");
    AST_DONE_SRC: assert property ($rose(cmdDoneFlag) |-> $past(cmdGenDone, 2)
        || $past(cmdGenDone, 3) || $past(cmdGenDone, 4)) else $error("done without cause");
    COV_ALARM: cover property ($rose(overloadAlarm));
    COV_WARN: cover property ($rose(warnFlag));
    COV_DONE: cover property ($rose(cmdDoneFlag));
endmodule
bind ssof_status_flags ssof_checker #(.OVL_CYCLES(OVL_CYCLES)) ssof_checker_i (
    .ref_clk(ref_clk), .nrst(nrst), .overloadIn(overloadIn), .revLimitErr(revLimitErr),
    .fwdLimitErr(fwdLimitErr), .emergencyStop(emergencyStop), .serialCommErr(serialCommErr),
    .underVoltage(underVoltage), .otherFault(otherFault), .posCmdOverflow(posCmdOverflow),
    .cmdStart(cmdStart), .cmdGenDone(cmdGenDone), .overloadWarnFlag(overloadWarnFlag),
    .servoFaultFlag(servoFaultFlag), .warnFlag(warnFlag), .overloadAlarm(overloadAlarm),
    .cmdDoneFlag(cmdDoneFlag), .warnPercent(warnPercent), .doFuncCode(doFuncCode),
    .doOut(doOut));

// ### test/ssof_status_flags_tb.sv
// Self-checking bench for the status flag block
`timescale 1ns/10ps
module ssof_status_flags_tb;
    logic        ref_clk = 0, nrst = 0, overloadIn = 0, cmdStart = 0, cmdGenDone = 0;
    logic [6:0]  warnPercent = 7'h3C;               // Sixty percent
    logic [8:0]  cond = 9'h000;                     // Warning, fault, limit causes
    logic [63:0] codes = 64'h0015141312111007;      // One function code per output
    logic [7:0]  doOut, seenOut, expOut;
    logic        ovw, flt, wrn, alm, dne;
    int          fails = 0, samplesChecked = 0, n, seed = 32'hc0d9874a, w;
    always #5 ref_clk = ~ref_clk;
    ssof_status_flags #(.OVL_CYCLES(40'h0000000064)) ssof_status_flags_i (.ref_clk(ref_clk),
        .nrst(nrst), .overloadIn(overloadIn), .warnPercent(warnPercent),
        .revLimitErr(cond[0]), .fwdLimitErr(cond[1]), .emergencyStop(cond[2]),
        .serialCommErr(cond[3]), .underVoltage(cond[4]), .otherFault(cond[5]),
        .posCmdOverflow(cond[6]), .revSoftReached(cond[7]), .fwdSoftReached(cond[8]),
        .cmdStart(cmdStart), .cmdGenDone(cmdGenDone), .doFuncCode(codes), .doOut(doOut),
        .overloadWarnFlag(ovw), .servoFaultFlag(flt), .warnFlag(wrn), .overloadAlarm(alm),
        .cmdDoneFlag(dne));
    ssof_host_model ssof_host_model_i (.ref_clk(ref_clk), .doOut(doOut), .seenOut(seenOut));
    // Compare and count
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        samplesChecked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        step(2);
        nrst <= 1;
        cmdGenDone <= 1;                               // No command running yet
        step(8);
        chk("doneIdle", 0, dne);
        cmdGenDone <= 0;
        cmdStart <= 1;
        step(1);
        cmdStart <= 0;
        step(8);
        chk("doneRun", 0, dne);
        cmdGenDone <= 1;
        step(8);
        cmdGenDone <= 0;
        step(8);
        chk("doneHeld", 1, dne);
        cmdStart <= 1;
        step(1);
        cmdStart <= 0;
        step(8);
        chk("doneRestart", 0, dne);
        cmdGenDone <= 1;
        step(1);
        cmdGenDone <= 0;
        step(8);
        chk("doneAgain", 1, dne);
        $display("Command test done");
        for (int i = 0; i < 24; i++) begin
            cond <= 9'($random(seed));
            step(9);
            w = |cond[4:0];
            expOut = {1'b0, 1'b1, cond[8], cond[7], cond[6], 1'(w), 1'b0, 1'(w | cond[5])};
            chk("doOut", expOut, seenOut);
            chk("warn", 8'(w), 8'(wrn));
        end
        $display("Mapping test done");
        cond <= 9'h000;
        step(8);
        overloadIn <= 1;
        n = 0;
        while (ovw !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        chk("warnAt", 1, 8'(n > 60 && n <= 68));
        while (alm !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        chk("alarmAt", 1, 8'(n > 100 && n <= 108));
        step(3);
        chk("fault", 1, 8'(flt));
        chk("doOvlFault", 8'h03, seenOut & 8'h03);
        overloadIn <= 0;
        step(8);
        chk("alarmHeld", 1, 8'(alm));
        chk("warnGone", 0, 8'(ovw));
        $display("Overload test done");
        nrst <= 0;
        step(2);
        nrst <= 1;
        step(4);
        chk("alarmReset", 0, 8'(alm));
        chk("faultReset", 0, 8'(flt));
        $display("Reset test done");
        wrap_up();
    end
endmodule
